// *** acr_pkg.sv ***
// Shared constants and types of the converter channel and touch readout block
package acr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] ACR_IDX_RESULT0 = 8'h00;
  localparam logic [7:0] ACR_IDX_SLOT0 = 8'h20;
  localparam logic [7:0] ACR_IDX_FLAGS = 8'h5F;
  localparam logic [7:0] ACR_IDX_MASK = 8'h60;
  localparam logic [7:0] ACR_IDX_CTRL1 = 8'h61;
  localparam logic [7:0] ACR_IDX_GAIN_LOW = 8'h62;
  localparam logic [7:0] ACR_IDX_GAIN_HIGH = 8'h63;
  localparam logic [7:0] ACR_IDX_EXTRA = 8'h64;
  localparam int ACR_ENTRIES = 32;

  // Field positions
  localparam int ACR_FLAG_ROUND_BIT = 0;
  localparam int ACR_FLAG_PEN_BIT = 1;
  localparam int ACR_CTRL_SLEEP_LSB = 0;
  localparam int ACR_CTRL_PEN_EN_BIT = 5;
  localparam int ACR_CTRL_START_BIT = 6;
  localparam int ACR_CTRL_ENABLE_BIT = 7;
  localparam int ACR_EXTRA_SUPPLY_BIT = 0;
  localparam int ACR_EXTRA_COIN_BIT = 1;
  localparam int ACR_SLOT_BIAS_LSB = 5;

  // Reset value and masks of the writable bits
  localparam logic [7:0] ACR_RST_BYTE = 8'h00;
  localparam logic [1:0] ACR_FLAG_MASK_BITS = 2'h3;
  localparam logic [3:0] ACR_GAIN_HIGH_BITS = 4'hF;
  localparam logic [1:0] ACR_EXTRA_BITS = 2'h3;

  // Channel numbers
  localparam logic [4:0] ACR_CH_TEMP = 5'h00;
  localparam logic [4:0] ACR_CH_ISENSE_FIRST = 5'h01;
  localparam logic [4:0] ACR_CH_ISENSE_LAST = 5'h05;
  localparam logic [4:0] ACR_CH_BATTERY = 5'h06;
  localparam logic [4:0] ACR_CH_GP_FIRST = 5'h0A;
  localparam logic [4:0] ACR_CH_TOUCH_LAST = 5'h0D;
  localparam logic [4:0] ACR_CH_GP_LAST = 5'h15;
  localparam logic [4:0] ACR_CH_SUPPLY = 5'h16;
  localparam logic [4:0] ACR_CH_COIN = 5'h19;
  localparam logic [4:0] ACR_CH_STOP = 5'h1F;
  localparam logic [2:0] ACR_BIAS_NONE = 3'h0;

  // Code figures of the dedicated channels
  localparam logic [9:0] ACR_TEMP_CODE_25C = 10'h2C1;
  localparam logic [9:0] ACR_CODE_FULL = 10'h3FF;
  localparam logic [9:0] ACR_CODE_ZERO = 10'h000;

  // Timing
  localparam int ACR_CLK_PERIOD_PS = 5000;
  localparam int ACR_SLEEP_STEP_US = 4500;
  // Divide first so that the product stays inside 32 bits
  localparam int ACR_SLEEP_STEP_CYCLES = ACR_SLEEP_STEP_US * (1000000 / ACR_CLK_PERIOD_PS);
  localparam logic [2:0] ACR_SLEEP_NO_LOOP = 3'h7;
  localparam int ACR_SETTLE_MAX_NS = 5500;
  localparam int ACR_SETTLE_MAX_CYCLES = ACR_SETTLE_MAX_NS * 1000 / ACR_CLK_PERIOD_PS;

  // AXI responses
  localparam logic [1:0] ACR_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACR_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic start;
    logic [4:0] chan;
    logic [2:0] bias;
    logic gain;
  } acr_conv_req_type;

  typedef struct packed {
    logic done;
    logic [9:0] code;
  } acr_conv_rsp_type;

  typedef struct packed {
    logic gain;
    logic [9:0] code;
  } acr_result_type;

  typedef enum logic [2:0] {
    ACR_IDLE,
    ACR_FETCH,
    ACR_CONVERT,
    ACR_SLEEP,
    ACR_HALT
  } acr_state_type;

endpackage

// *** acr_seq.sv ***
// Slot walker that drives conversions and stores results
`timescale 1ns/1ps
`default_nettype none
module acr_seq
  import acr_pkg::*;
#(
  parameter int SLEEP_STEP_CYCLES = ACR_SLEEP_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic start,
  input wire logic [2:0] sleep_code,
  input wire logic supply_en,
  input wire logic coin_en,
  input wire logic [11:0] gain_bits,
  // Slot table
  output logic [4:0] slot_idx,
  input wire logic [7:0] slot_entry,
  // Converter
  output acr_conv_req_type conv_req,
  input wire acr_conv_rsp_type conv_rsp,
  // Results
  output logic res_we,
  output logic [4:0] res_idx,
  output acr_result_type res_data,
  output logic round_done
);

  function automatic logic gain_for(input logic [4:0] chan, input logic [2:0] bias, input logic [11:0] gains);
    logic [4:0] off;
    off = chan - ACR_CH_GP_FIRST;
    if (chan < ACR_CH_GP_FIRST || chan > ACR_CH_GP_LAST) begin
      gain_for = 1'b0;
    end else if (chan <= ACR_CH_TOUCH_LAST && bias != ACR_BIAS_NONE) begin
      gain_for = 1'b0;
    end else begin
      gain_for = gains[off[3:0]];
    end
  endfunction

  acr_state_type state_q;
  logic [31:0] sleep_cnt_q;

  wire logic [4:0] slot_chan = slot_entry[4:0];
  wire logic [2:0] slot_bias = slot_entry[7:ACR_SLOT_BIAS_LSB];
  wire logic chan_gated = (slot_chan == ACR_CH_SUPPLY && !supply_en) || (slot_chan == ACR_CH_COIN && !coin_en);
  wire logic last_slot = (slot_idx == ACR_CH_STOP);
  wire logic [31:0] sleep_total = 32'(sleep_code) * 32'(SLEEP_STEP_CYCLES);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ACR_IDLE;
      slot_idx <= 5'h00;
      conv_req <= '0;
      res_we <= 1'b0;
      res_idx <= 5'h00;
      res_data <= '0;
      round_done <= 1'b0;
      sleep_cnt_q <= 32'h0000_0000;
    end else begin
      conv_req.start <= 1'b0;
      res_we <= 1'b0;
      round_done <= 1'b0;
      if (!enable) begin
        state_q <= ACR_IDLE;
      end else begin
        case (state_q)
          ACR_IDLE: begin
            slot_idx <= 5'h00;
            if (start) begin
              state_q <= ACR_FETCH;
            end
          end
          ACR_FETCH: begin
            if (slot_chan == ACR_CH_STOP) begin
              round_done <= 1'b1;
              sleep_cnt_q <= sleep_total;
              state_q <= (sleep_code == ACR_SLEEP_NO_LOOP) ? ACR_HALT : ACR_SLEEP;
            end else if (chan_gated) begin
              res_we <= 1'b1;
              res_idx <= slot_idx;
              res_data <= '0;
              slot_idx <= slot_idx + 5'h01;
              if (last_slot) begin
                round_done <= 1'b1;
                sleep_cnt_q <= sleep_total;
                state_q <= (sleep_code == ACR_SLEEP_NO_LOOP) ? ACR_HALT : ACR_SLEEP;
              end
            end else begin
              conv_req.start <= 1'b1;
              conv_req.chan <= slot_chan;
              conv_req.bias <= slot_bias;
              conv_req.gain <= gain_for(slot_chan, slot_bias, gain_bits);
              state_q <= ACR_CONVERT;
            end
          end
          ACR_CONVERT: begin
            if (conv_rsp.done) begin
              res_we <= 1'b1;
              res_idx <= slot_idx;
              res_data <= {conv_req.gain, conv_rsp.code};
              slot_idx <= slot_idx + 5'h01;
              state_q <= ACR_FETCH;
              if (last_slot) begin
                round_done <= 1'b1;
                sleep_cnt_q <= sleep_total;
                state_q <= (sleep_code == ACR_SLEEP_NO_LOOP) ? ACR_HALT : ACR_SLEEP;
              end
            end
          end
          ACR_SLEEP: begin
            slot_idx <= 5'h00;
            if (sleep_cnt_q != 32'h0000_0000) begin
              sleep_cnt_q <= sleep_cnt_q - 32'h0000_0001;
            end else begin
              state_q <= start ? ACR_FETCH : ACR_IDLE;
            end
          end
          ACR_HALT: begin
            slot_idx <= 5'h00;
            if (!start) begin
              state_q <= ACR_IDLE;
            end
          end
          default: begin
            state_q <= ACR_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** acr_top.sv ***
// Converter channel readout with touch support behind an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Channel 0 returns the raw die temperature code; 0x2C1 near 25 degrees.
// - Regulator load currents are converted on channels one to five as readings.
// - Channel 6 returns battery voltage; full code means 4.800 V, zero means 0 V.
// - Twelve general inputs, channels 10 to 21, are converted from the slot table.
// - Gain bit clear selects unity, 2.0 V range; set selects tenfold, 200 mV.
// - Channel 22 converts the halved supply only with the supply enable set.
// - Channel 25 converts the scaled coin cell only with the coin enable set.
// - Plates sit on inputs 10 to 13; bias bits live in the slot entries.
// - With pen bias enabled, a pen touch sets the pen flag and interrupts.
// - Position code runs 0 at the negative terminal to 1023 at the positive.
// - Contact reading is the current source drop times two, stored raw.
// - Pen flag is bit 1 of the flags; mask bit 1 keeps it from the interrupt, the flag still sets.
// - Gains of 10 to 17 sit low, 18 to 21 high; touch bias ignores 10-13.
// - Each result holds the ten-bit code with the gain bit on top.
module acr_top
  import acr_pkg::*;
#(
  parameter int SLEEP_STEP_CYCLES = ACR_SLEEP_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter front end
  output acr_conv_req_type conv_req,
  input wire acr_conv_rsp_type conv_rsp,
  // Analog controls and pen sense
  output logic supply_channel_enable,
  output logic coin_channel_enable,
  output logic pen_detect_bias_enable,
  input wire logic pen_touch_raw,
  // Interrupt
  output logic host_interrupt_pin
);

  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    reg_index = addr[9:2];
  endfunction

  function automatic logic is_mapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    is_mapped = (addr[11:10] == 2'h0) && (idx <= ACR_IDX_EXTRA);
  endfunction

  // Register state
  logic [1:0] flags_q;
  logic [1:0] mask_q;
  logic [7:0] ctrl1_q;
  logic [7:0] gain_low_q;
  logic [3:0] gain_high_q;
  logic [1:0] extra_q;
  logic [7:0] slot_mem [ACR_ENTRIES];
  acr_result_type result_mem [ACR_ENTRIES];

  // Bus state
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // Pen sense synchroniser
  logic pen_meta_q;
  logic pen_sync_q;
  logic pen_prev_q;

  // Sequencer links
  logic [4:0] slot_idx;
  logic res_we;
  logic [4:0] res_idx;
  acr_result_type res_data;
  logic round_done;
  acr_conv_req_type seq_req;

  // Write path decode
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  wire logic [7:0] wr_idx = reg_index(aw_addr_q);
  wire logic wr_ok = is_mapped(aw_addr_q);
  wire logic wr_lane0 = wr_fire && wr_ok && w_strb_q[0];
  wire logic wr_flags = wr_lane0 && (wr_idx == ACR_IDX_FLAGS);
  wire logic wr_mask = wr_lane0 && (wr_idx == ACR_IDX_MASK);
  wire logic wr_ctrl1 = wr_lane0 && (wr_idx == ACR_IDX_CTRL1);
  wire logic wr_gain_low = wr_lane0 && (wr_idx == ACR_IDX_GAIN_LOW);
  wire logic wr_gain_high = wr_lane0 && (wr_idx == ACR_IDX_GAIN_HIGH);
  wire logic wr_extra = wr_lane0 && (wr_idx == ACR_IDX_EXTRA);
  wire logic wr_slot = wr_lane0 && (wr_idx >= ACR_IDX_SLOT0) && (wr_idx < ACR_IDX_FLAGS);
  wire logic [4:0] wr_slot_idx = wr_idx[4:0];

  // Read path decode
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic [7:0] rd_idx = reg_index(s_axi_araddr);
  wire logic rd_ok = is_mapped(s_axi_araddr);
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_idx < ACR_IDX_SLOT0) begin
      rd_word = {21'h00_0000, result_mem[rd_idx[4:0]]};
    end else if (rd_idx < ACR_IDX_FLAGS) begin
      rd_word = {24'h00_0000, slot_mem[rd_idx[4:0]]};
    end else if (rd_idx == ACR_IDX_FLAGS) begin
      rd_word = {30'h0000_0000, flags_q};
    end else if (rd_idx == ACR_IDX_MASK) begin
      rd_word = {30'h0000_0000, mask_q};
    end else if (rd_idx == ACR_IDX_CTRL1) begin
      rd_word = {24'h00_0000, ctrl1_q};
    end else if (rd_idx == ACR_IDX_GAIN_LOW) begin
      rd_word = {24'h00_0000, gain_low_q};
    end else if (rd_idx == ACR_IDX_GAIN_HIGH) begin
      rd_word = {28'h000_0000, gain_high_q};
    end else if (rd_idx == ACR_IDX_EXTRA) begin
      rd_word = {30'h0000_0000, extra_q};
    end
  end

  // Pen touch event and interrupt sources
  wire logic pen_rise = pen_sync_q && !pen_prev_q;
  wire logic pen_event = pen_rise && ctrl1_q[ACR_CTRL_PEN_EN_BIT];
  wire logic [1:0] flag_set = {pen_event, round_done};
  wire logic [1:0] flag_clr = wr_flags ? w_data_q[1:0] : 2'h0;
  wire logic [1:0] flags_d = flag_set | (flags_q & ~flag_clr);
  wire logic irq_d = |(flags_d & ~mask_q);

  // Write address and data capture, either order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ACR_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? ACR_RESP_OKAY : ACR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ACR_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_ok ? rd_word : 32'h0000_0000;
      s_axi_rresp <= rd_ok ? ACR_RESP_OKAY : ACR_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= ACR_RST_BYTE[1:0];
      ctrl1_q <= ACR_RST_BYTE;
      gain_low_q <= ACR_RST_BYTE;
      gain_high_q <= ACR_RST_BYTE[3:0];
      extra_q <= ACR_RST_BYTE[1:0];
    end else begin
      if (wr_mask) begin
        mask_q <= w_data_q[1:0] & ACR_FLAG_MASK_BITS;
      end
      if (wr_ctrl1) begin
        ctrl1_q <= w_data_q[7:0];
      end
      if (wr_gain_low) begin
        gain_low_q <= w_data_q[7:0];
      end
      if (wr_gain_high) begin
        gain_high_q <= w_data_q[3:0] & ACR_GAIN_HIGH_BITS;
      end
      if (wr_extra) begin
        extra_q <= w_data_q[1:0] & ACR_EXTRA_BITS;
      end
    end
  end

  // Sticky flags, a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= ACR_RST_BYTE[1:0];
      host_interrupt_pin <= 1'b0;
    end else begin
      flags_q <= flags_d;
      host_interrupt_pin <= irq_d;
    end
  end

  // Slot table and result file
  always_ff @(posedge clk) begin
    if (wr_slot) begin
      slot_mem[wr_slot_idx] <= w_data_q[7:0];
    end
    if (res_we) begin
      result_mem[res_idx] <= res_data;
    end
  end

  // Pen sense synchroniser and edge history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pen_meta_q <= 1'b0;
      pen_sync_q <= 1'b0;
      pen_prev_q <= 1'b0;
    end else begin
      pen_meta_q <= pen_touch_raw;
      pen_sync_q <= pen_meta_q;
      pen_prev_q <= pen_sync_q;
    end
  end

  // Analog enables and registered converter request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      supply_channel_enable <= 1'b0;
      coin_channel_enable <= 1'b0;
      pen_detect_bias_enable <= 1'b0;
      conv_req <= '0;
    end else begin
      supply_channel_enable <= extra_q[ACR_EXTRA_SUPPLY_BIT];
      coin_channel_enable <= extra_q[ACR_EXTRA_COIN_BIT];
      pen_detect_bias_enable <= ctrl1_q[ACR_CTRL_PEN_EN_BIT];
      conv_req <= seq_req;
    end
  end

  acr_seq #(
    .SLEEP_STEP_CYCLES(SLEEP_STEP_CYCLES)
  ) u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .enable(ctrl1_q[ACR_CTRL_ENABLE_BIT]),
    .start(ctrl1_q[ACR_CTRL_START_BIT]),
    .sleep_code(ctrl1_q[ACR_CTRL_SLEEP_LSB +: 3]),
    .supply_en(extra_q[ACR_EXTRA_SUPPLY_BIT]),
    .coin_en(extra_q[ACR_EXTRA_COIN_BIT]),
    .gain_bits({gain_high_q, gain_low_q}),
    .slot_idx(slot_idx),
    .slot_entry(slot_mem[slot_idx]),
    .conv_req(seq_req),
    .conv_rsp(conv_rsp),
    .res_we(res_we),
    .res_idx(res_idx),
    .res_data(res_data),
    .round_done(round_done)
  );

endmodule
`default_nettype wire

// *** acr_top_assertions.sv ***
// Concurrent checks on the ports of the converter readout block
`timescale 1ns/1ps
`default_nettype none
module acr_checker
  import acr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register read channel
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Converter and analog controls
  input wire acr_conv_req_type conv_req,
  input wire logic supply_channel_enable,
  input wire logic coin_channel_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire st = conv_req.start;
  wire [4:0] ch = conv_req.chan;
  wire gp = (ch >= ACR_CH_GP_FIRST) && (ch <= ACR_CH_GP_LAST);
  wire plate = (ch >= ACR_CH_GP_FIRST) && (ch <= ACR_CH_TOUCH_LAST);

  start_pulse_a: assert property (st |=> !st ##1 !st)
    else $error("conversion start longer than one cycle");
  req_hold_a: assert property (!st |-> $stable({conv_req.chan, conv_req.bias, conv_req.gain}))
    else $error("request fields moved between starts");
  gain_range_a: assert property (st && !gp |-> !conv_req.gain)
    else $error("gain set outside general channels");
  plate_gain_a: assert property (st && plate && (conv_req.bias != ACR_BIAS_NONE) |-> !conv_req.gain)
    else $error("gain set on a biased plate input");
  supply_gate_a: assert property (st && (ch == ACR_CH_SUPPLY) |-> supply_channel_enable)
    else $error("supply channel converted while disabled");
  coin_gate_a: assert property (st && (ch == ACR_CH_COIN) |-> coin_channel_enable)
    else $error("coin channel converted while disabled");
  stop_code_a: assert property (st |-> ch != ACR_CH_STOP)
    else $error("stop entry sent to the converter");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
endmodule

bind acr_top acr_checker chk_u (.*);
`default_nettype wire

// *** acr_conv_model.sv ***
// Behavioural converter front end answering conversion requests
`timescale 1ns/1ps
`default_nettype none
module acr_conv_model
  import acr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Converter request and answer
  input wire acr_conv_req_type conv_req,
  output acr_conv_rsp_type conv_rsp,
  // Answer delay in cycles, two or more
  input wire logic [3:0] lat
);
  logic [3:0] cnt_q;
  logic [9:0] code_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      code_q <= 10'h000;
    end else if (conv_req.start) begin
      cnt_q <= lat;
      if (conv_req.chan == ACR_CH_TEMP) code_q <= ACR_TEMP_CODE_25C;
      else if (conv_req.chan == ACR_CH_BATTERY) code_q <= ACR_CODE_FULL;
      else code_q <= {conv_req.chan, ~conv_req.chan};
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // Outside the answer cycle the code lines show the inverse of the last code
  assign conv_rsp.done = (cnt_q == 4'h1);
  assign conv_rsp.code = conv_rsp.done ? code_q : ~code_q;
endmodule
`default_nettype wire

// *** tb_acr_top.sv ***
// Self-checking bench of the converter readout block
`timescale 1ns/1ps
`default_nettype none
module tb_acr_top;
  import acr_pkg::*;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, pen;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [3:0] lat, gh;
  logic [7:0] gl;
  logic [1:0] ex, r;
  wire logic awready, wready, bvalid, arready, rvalid, irq, sup_en, coin_en, pen_en;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire acr_conv_req_type req;
  wire acr_conv_rsp_type rsp;
  integer seed;
  int miscompares, n_compared, n, i, k;
  logic [7:0] slot [13];
  logic [7:0] base [13] = '{8'h00, 8'h01, 8'h05, 8'h06, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h12, 8'h15, 8'h16, 8'h19};

  acr_top #(.SLEEP_STEP_CYCLES(4)) dut_u (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_req(req), .conv_rsp(rsp),
    .supply_channel_enable(sup_en), .coin_channel_enable(coin_en), .pen_detect_bias_enable(pen_en),
    .pen_touch_raw(pen), .host_interrupt_pin(irq));
  acr_conv_model conv_u (.clk(clk), .rst_n(rst_n), .conv_req(req), .conv_rsp(rsp), .lat(lat));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] exp_res(input logic [7:0] s);
    logic [4:0] c;
    logic [11:0] gb;
    logic g;
    c = s[4:0];
    gb = {gh, gl};
    g = (c >= ACR_CH_GP_FIRST && c <= ACR_CH_GP_LAST) ? gb[c - ACR_CH_GP_FIRST] : 1'b0;
    if (c <= ACR_CH_TOUCH_LAST && s[7:5] != 3'h0) g = 1'b0;
    if ((c == 5'h16 && !ex[0]) || (c == 5'h19 && !ex[1])) return 32'h0;
    if (c == 5'h00) return {21'h0, g, 10'h2C1};
    if (c == 5'h06) return {21'h0, g, 10'h3FF};
    return {21'h0, g, c, ~c};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    stop_test;
  end

  initial begin
    seed = 32'h5acd6bfd;
    {rst_n, awvalid, wvalid, bready, arvalid, rready, pen} = '0;
    {awaddr, araddr, wdata} = '0;
    lat = 4'h2;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 8'h5F; i <= 8'h64; i++) begin
      rd(i[7:0], d, r);
      chk(d, 32'h0);
    end
    rd(8'h65, d, r);
    chk(r, ACR_RESP_SLVERR);
    wr(8'h70, 32'h3, r);
    chk(r, ACR_RESP_SLVERR);
    for (n = 0; n < 3; n++) begin
      gl = 8'($random(seed));
      gh = 4'($random(seed));
      ex = 2'($random(seed));
      lat <= 4'h2 + 4'($random(seed) & 7);
      // Plates carry no bias in the first round, as without a touch screen
      for (i = 0; i < 13; i++) begin
        slot[i] = base[i];
        if (i == 8) slot[i][4:0] = 5'h0E + 5'($random(seed) & 7);
        if (n > 0 && i >= 4 && i <= 7) slot[i][7:5] = 3'($random(seed));
        wr(ACR_IDX_SLOT0 + i[7:0], {24'h0, slot[i]}, r);
        chk(r, ACR_RESP_OKAY);
      end
      wr(ACR_IDX_SLOT0 + 8'h0D, 32'h1F, r);
      wr(ACR_IDX_GAIN_LOW, {24'h0, gl}, r);
      wr(ACR_IDX_GAIN_HIGH, {28'h0, gh}, r);
      wr(ACR_IDX_EXTRA, {30'h0, ex}, r);
      rd(ACR_IDX_GAIN_HIGH, d, r);
      chk(d, {28'h0, gh});
      chk({sup_en, coin_en}, {ex[0], ex[1]});
      repeat (ACR_SETTLE_MAX_CYCLES) @(posedge clk);
      wr(ACR_IDX_CTRL1, 32'hC7, r);
      k = 0;
      while (irq !== 1'b1 && k < 3000) begin
        @(posedge clk);
        k++;
      end
      chk(irq, 1'b1);
      for (i = 0; i < 13; i++) begin
        rd(ACR_IDX_RESULT0 + i[7:0], d, r);
        chk(d, exp_res(slot[i]));
      end
      wr(ACR_IDX_FLAGS, 32'h1, r);
      rd(ACR_IDX_FLAGS, d, r);
      chk(d, 32'h0);
      chk(irq, 1'b0);
      wr(ACR_IDX_CTRL1, 32'h0, r);
    end
    // Looping rounds with a short sleep: a cleared round flag is set again by the next round
    wr(ACR_IDX_CTRL1, 32'hC1, r);
    for (n = 0; n < 2; n++) begin
      k = 0;
      while (irq !== 1'b1 && k < 3000) begin
        @(posedge clk);
        k++;
      end
      chk(irq, 1'b1);
      wr(ACR_IDX_FLAGS, 32'h1, r);
    end
    wr(ACR_IDX_CTRL1, 32'h0, r);
    rd(ACR_IDX_RESULT0, d, r);
    chk(d, exp_res(slot[0]));
    // Pen touch while masked, then unmasked, then without pen bias
    wr(ACR_IDX_CTRL1, 32'h20, r);
    @(posedge clk);
    chk(pen_en, 1'b1);
    wr(ACR_IDX_MASK, 32'h2, r);
    pen <= 1'b1;
    repeat (10) @(posedge clk);
    rd(ACR_IDX_FLAGS, d, r);
    chk(d, 32'h2);
    chk(irq, 1'b0);
    wr(ACR_IDX_MASK, 32'h0, r);
    rd(ACR_IDX_MASK, d, r);
    chk(d, 32'h0);
    chk(irq, 1'b1);
    pen <= 1'b0;
    wr(ACR_IDX_FLAGS, 32'h2, r);
    rd(ACR_IDX_FLAGS, d, r);
    chk(d, 32'h0);
    wr(ACR_IDX_CTRL1, 32'h0, r);
    pen <= 1'b1;
    repeat (10) @(posedge clk);
    rd(ACR_IDX_FLAGS, d, r);
    chk(d, 32'h0);
    chk(irq, 1'b0);
    stop_test;
  end
endmodule
`default_nettype wire
